// ---- design/srxd_buf.sv ----
// Write offset and first-error tracker of one receive DMA buffer.
`timescale 1ns/1ps
module srxd_buf #(
  parameter int OFS_W = 14
) (
  // Clock, reset and enable.
  input  wire logic             ref_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             clk_en_i,
  // Commands from software and the DMA.
  input  wire logic             dma_rst_i,
  input  wire logic             load_i,
  input  wire logic             ofs_wr_i,
  input  wire logic [OFS_W-1:0] ofs_wdata_i,
  // Byte store into this buffer.
  input  wire logic             store_i,
  input  wire logic             err_any_i,
  input  wire logic             err_ovf_only_i,
  input  wire logic [OFS_W-1:0] begin_addr_i,
  input  wire logic [OFS_W-1:0] end_addr_i,
  // State and events.
  output logic                  loaded_o,
  output logic [OFS_W-1:0]      offset_o,
  output logic [OFS_W-1:0]      err_offset_o,
  output logic                  at_end_o,
  output logic                  unload_ev_o,
  output logic                  err_ev_o
);

  srxd_pkg::srxd_buf_state_t s;
  srxd_pkg::srxd_buf_state_t next_s;
  logic [OFS_W-1:0]          cur_addr;

  // The buffer is full when the next store lands on its end address.
  assign cur_addr     = OFS_W'(begin_addr_i + s.offset);
  assign at_end_o     = s.loaded && (cur_addr == end_addr_i);
  assign loaded_o     = s.loaded;
  assign offset_o     = s.offset;
  assign err_offset_o = s.err_seen ? s.err_offset : '0;
  assign unload_ev_o  = clk_en_i && store_i && at_end_o && !dma_rst_i &&
                        !load_i;
  assign err_ev_o     = clk_en_i && store_i && err_any_i && !s.err_seen &&
                        !dma_rst_i && !load_i;

  // Next state: reset beats load, load beats software write, then stores.
  always_comb begin
    next_s = s;
    if (dma_rst_i) begin
      next_s = srxd_pkg::BUF_RESET;
    end else if (load_i) begin
      next_s.loaded   = 1'b1;
      next_s.offset   = '0;
      next_s.err_seen = 1'b0;
    end else begin
      if (store_i && s.loaded) begin
        next_s.offset = OFS_W'(s.offset + 1'b1);
        if (at_end_o) begin
          next_s.loaded = 1'b0;
        end
        if (err_any_i && !s.err_seen) begin
          next_s.err_seen   = 1'b1;
          next_s.err_offset = err_ovf_only_i ?
            OFS_W'(s.offset - srxd_pkg::OVF_BACKOFF) : s.offset;
        end
      end
      if (ofs_wr_i) begin
        next_s.offset = ofs_wdata_i;
        if (!s.loaded) begin
          next_s.loaded   = 1'b1;
          next_s.err_seen = 1'b0;
        end
      end
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      s <= srxd_pkg::BUF_RESET;
    end else if (clk_en_i) begin
      s <= next_s;
    end
  end

endmodule // srxd_buf

// ---- design/srxd_pkg.sv ----
// Shared constants, register map and carrier types of the receive DMA tracker.
package srxd_pkg;

  // Widths and buffer indices.
  localparam int OFS_W   = 14;
  localparam int NUM_BUF = 2;
  localparam int BUF_A   = 0;
  localparam int BUF_B   = 1;
  localparam int EV_W    = 5;

  // Register byte addresses on the Avalon bus.
  localparam logic [31:0] ADDR_BEGIN_A  = 32'h4000c800;
  localparam logic [31:0] ADDR_END_A    = 32'h4000c804;
  localparam logic [31:0] ADDR_BEGIN_B  = 32'h4000c808;
  localparam logic [31:0] ADDR_END_B    = 32'h4000c80c;
  localparam logic [31:0] ADDR_WR_OFS_A = 32'h4000c820;
  localparam logic [31:0] ADDR_WR_OFS_B = 32'h4000c824;
  localparam logic [31:0] ADDR_ERR_A    = 32'h4000c834;
  localparam logic [31:0] ADDR_ERR_B    = 32'h4000c838;
  localparam logic [31:0] ADDR_SAVED    = 32'h4000c870;
  localparam logic [31:0] ADDR_CTRL     = 32'h4000c880;
  localparam logic [31:0] ADDR_STAT     = 32'h4000c884;
  localparam logic [31:0] ADDR_INT_STAT = 32'h4000c888;
  localparam logic [31:0] ADDR_INT_MASK = 32'h4000c88c;

  // Constant upper bits that begin and end address registers read back.
  localparam logic [31:0] ADDR_REG_HIGH = 32'h20000000;

  // Control register bits.
  localparam int CTRL_DMA_RST = 0;
  localparam int CTRL_LOAD_A  = 1;
  localparam int CTRL_LOAD_B  = 2;
  localparam int CTRL_SPI_SLV = 3;

  // Status register bits.
  localparam int STAT_LOADED_A = 0;
  localparam int STAT_LOADED_B = 1;
  localparam int STAT_ACTIVE_B = 2;
  localparam int STAT_SAVED    = 3;

  // Interrupt event bits.
  localparam int EV_UNLOAD_A = 0;
  localparam int EV_UNLOAD_B = 1;
  localparam int EV_ERR_A    = 2;
  localparam int EV_ERR_B    = 3;
  localparam int EV_SAVED    = 4;

  // Overflow is seen at the FIFO input, four bytes ahead of the store.
  localparam logic [OFS_W-1:0] OVF_BACKOFF = 14'h0004;

  // One received byte leaving the receive FIFO, with its error flags.
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       parity_err;
    logic       frame_err;
    logic       overflow_err;
  } srxd_rx_byte_t;

  // One byte write towards system RAM.
  typedef struct packed {
    logic             wr;
    logic [OFS_W-1:0] addr;
    logic [7:0]       data;
  } srxd_mem_wr_t;

  // State of one receive buffer tracker.
  typedef struct packed {
    logic             loaded;
    logic             err_seen;
    logic [OFS_W-1:0] offset;
    logic [OFS_W-1:0] err_offset;
  } srxd_buf_state_t;

  localparam srxd_buf_state_t BUF_RESET = '0;

  // Bus slave states, one-hot.
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } srxd_bus_state_t;

  // State of the top level.
  typedef struct packed {
    srxd_bus_state_t                  bus;
    logic [31:0]                      rdata;
    logic [NUM_BUF-1:0][OFS_W-1:0]    begin_addr;
    logic [NUM_BUF-1:0][OFS_W-1:0]    end_addr;
    logic                             spi_slave;
    logic                             active_b;
    logic                             saved_valid;
    logic [OFS_W-1:0]                 saved_count;
    logic                             ss_n_prev;
    logic [EV_W-1:0]                  int_status;
    logic [EV_W-1:0]                  int_mask;
    srxd_mem_wr_t                     mem;
  } srxd_top_state_t;

  localparam srxd_top_state_t TOP_RESET = '{
    bus: BUS_IDLE, rdata: '0, begin_addr: '0, end_addr: '0,
    spi_slave: 1'b0, active_b: 1'b0, saved_valid: 1'b0,
    saved_count: '0, ss_n_prev: 1'b1, int_status: '0, int_mask: '0,
    mem: '0};

endpackage

// ---- design/srxd_top.sv ----
// Receive DMA offset, saved count and first-error tracking with Avalon regs.
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module srxd_top #(
  parameter int OFS_W = 14
) (
  // Clock, reset and enable.
  input  wire logic                  ref_clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  clk_en_i,
  // Avalon-MM slave.
  input  wire logic [31:0]           avs_address_i,
  input  wire logic                  avs_read_i,
  input  wire logic                  avs_write_i,
  input  wire logic [31:0]           avs_writedata_i,
  input  wire logic [3:0]            avs_byteenable_i,
  output logic [31:0]                avs_readdata_o,
  output logic                       avs_waitrequest_o,
  // Receive FIFO side.
  input  wire srxd_pkg::srxd_rx_byte_t rx_byte_i,
  output logic                       rx_ready_o,
  // SPI slave select, synchronous to the clock.
  input  wire logic                  slave_select_n_i,
  // Byte writes towards system RAM.
  output srxd_pkg::srxd_mem_wr_t     mem_wr_o,
  // Interrupt.
  output logic                       irq_o
);

  srxd_pkg::srxd_top_state_t s;
  srxd_pkg::srxd_top_state_t next_s;

  // Per-buffer wiring.
  logic [srxd_pkg::NUM_BUF-1:0]            buf_load;
  logic [srxd_pkg::NUM_BUF-1:0]            buf_ofs_wr;
  logic [srxd_pkg::NUM_BUF-1:0]            buf_store;
  logic [srxd_pkg::NUM_BUF-1:0]            buf_loaded;
  logic [srxd_pkg::NUM_BUF-1:0]            buf_at_end;
  logic [srxd_pkg::NUM_BUF-1:0]            buf_unload_ev;
  logic [srxd_pkg::NUM_BUF-1:0]            buf_err_ev;
  logic [srxd_pkg::NUM_BUF-1:0][OFS_W-1:0] buf_offset;
  logic [srxd_pkg::NUM_BUF-1:0][OFS_W-1:0] buf_err_offset;
  logic [srxd_pkg::NUM_BUF-1:0][OFS_W-1:0] buf_ofs_wdata;

  // Bus and data path decode.
  logic             bus_req;
  logic             wr_go;
  logic             dma_rst;
  logic [31:0]      ctrl_wdata;
  logic             sel_b;
  logic             store_go;
  logic             err_any;
  logic             err_ovf_only;
  logic             ss_deassert;
  logic [OFS_W-1:0] cur_count;
  logic [srxd_pkg::EV_W-1:0] events;
  logic [srxd_pkg::EV_W-1:0] int_clear;

  // Merges a write into an old word under the byte enables.
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wdata,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Widens a 14-bit field into a register word with zero upper bits.
  function automatic logic [31:0] field_word(input logic [OFS_W-1:0] f);
    return {{(32-OFS_W){1'b0}}, f};
  endfunction

  // A request is taken at the edge where waitrequest is low.
  assign bus_req           = avs_read_i || avs_write_i;
  assign avs_waitrequest_o = bus_req &&
                             (!clk_en_i || s.bus != srxd_pkg::BUS_ACK);
  assign avs_readdata_o    = s.rdata;
  assign wr_go             = clk_en_i && avs_write_i &&
                             (s.bus == srxd_pkg::BUS_ACK);
  assign ctrl_wdata        = be_merge(32'h00000000, avs_writedata_i,
                                      avs_byteenable_i);

  // Software commands towards the buffers.
  assign dma_rst = wr_go && (avs_address_i == srxd_pkg::ADDR_CTRL) &&
                   ctrl_wdata[srxd_pkg::CTRL_DMA_RST];
  assign buf_load[srxd_pkg::BUF_A] = wr_go &&
    (avs_address_i == srxd_pkg::ADDR_CTRL) &&
    ctrl_wdata[srxd_pkg::CTRL_LOAD_A];
  assign buf_load[srxd_pkg::BUF_B] = wr_go &&
    (avs_address_i == srxd_pkg::ADDR_CTRL) &&
    ctrl_wdata[srxd_pkg::CTRL_LOAD_B];
  assign buf_ofs_wr[srxd_pkg::BUF_A] = wr_go &&
    (avs_address_i == srxd_pkg::ADDR_WR_OFS_A);
  assign buf_ofs_wr[srxd_pkg::BUF_B] = wr_go &&
    (avs_address_i == srxd_pkg::ADDR_WR_OFS_B);

  // Stores go to the active buffer, or to the other one if it is idle.
  assign sel_b      = buf_loaded[srxd_pkg::BUF_B] &&
                      (s.active_b || !buf_loaded[srxd_pkg::BUF_A]);
  assign rx_ready_o = clk_en_i && (|buf_loaded);
  assign store_go   = clk_en_i && rx_byte_i.valid && rx_ready_o;
  assign buf_store[srxd_pkg::BUF_A] = store_go && !sel_b;
  assign buf_store[srxd_pkg::BUF_B] = store_go && sel_b;
  assign err_any      = rx_byte_i.parity_err || rx_byte_i.frame_err ||
                        rx_byte_i.overflow_err;
  assign err_ovf_only = rx_byte_i.overflow_err &&
                        !rx_byte_i.parity_err && !rx_byte_i.frame_err;
  assign cur_count    = buf_offset[sel_b];

  // Slave select rising means the master has ended the frame.
  assign ss_deassert = s.spi_slave && !s.ss_n_prev && slave_select_n_i;

  // Event collection for the sticky interrupt status.
  always_comb begin
    events = '0;
    events[srxd_pkg::EV_UNLOAD_A] = buf_unload_ev[srxd_pkg::BUF_A];
    events[srxd_pkg::EV_UNLOAD_B] = buf_unload_ev[srxd_pkg::BUF_B];
    events[srxd_pkg::EV_ERR_A]    = buf_err_ev[srxd_pkg::BUF_A];
    events[srxd_pkg::EV_ERR_B]    = buf_err_ev[srxd_pkg::BUF_B];
    events[srxd_pkg::EV_SAVED]    = clk_en_i && ss_deassert &&
                                    !s.saved_valid && !dma_rst;
    int_clear = '0;
    if (wr_go && (avs_address_i == srxd_pkg::ADDR_INT_STAT)) begin
      int_clear = ctrl_wdata[srxd_pkg::EV_W-1:0];
    end
  end

  // Interrupt is high while an unmasked status bit is set.
  assign irq_o    = |(s.int_status & s.int_mask);
  assign mem_wr_o = s.mem;

  // Buffer trackers, one per receive buffer.
  for (genvar g = 0; g < srxd_pkg::NUM_BUF; g++) begin : g_buf
    assign buf_ofs_wdata[g] = OFS_W'(be_merge(field_word(buf_offset[g]),
                                avs_writedata_i, avs_byteenable_i));
    srxd_buf #(
      .OFS_W (OFS_W)
    ) u_buf (
      .ref_clk_i      (ref_clk_i),
      .sys_rst_i      (sys_rst_i),
      .clk_en_i       (clk_en_i),
      .dma_rst_i      (dma_rst),
      .load_i         (buf_load[g]),
      .ofs_wr_i       (buf_ofs_wr[g]),
      .ofs_wdata_i    (buf_ofs_wdata[g]),
      .store_i        (buf_store[g]),
      .err_any_i      (err_any),
      .err_ovf_only_i (err_ovf_only),
      .begin_addr_i   (s.begin_addr[g]),
      .end_addr_i     (s.end_addr[g]),
      .loaded_o       (buf_loaded[g]),
      .offset_o       (buf_offset[g]),
      .err_offset_o   (buf_err_offset[g]),
      .at_end_o       (buf_at_end[g]),
      .unload_ev_o    (buf_unload_ev[g]),
      .err_ev_o       (buf_err_ev[g])
    );
  end

  // Next state of bus slave, registers, saved count and RAM write.
  always_comb begin
    next_s = s;
    // Bus handshake: one wait cycle, then the answer edge.
    unique case (s.bus)
      srxd_pkg::BUS_IDLE: begin
        if (bus_req) begin
          next_s.bus = srxd_pkg::BUS_ACK;
        end
        next_s.rdata = '0;
        if (avs_read_i) begin
          case (avs_address_i)
            srxd_pkg::ADDR_BEGIN_A: next_s.rdata = srxd_pkg::ADDR_REG_HIGH |
              field_word(s.begin_addr[srxd_pkg::BUF_A]);
            srxd_pkg::ADDR_END_A: next_s.rdata = srxd_pkg::ADDR_REG_HIGH |
              field_word(s.end_addr[srxd_pkg::BUF_A]);
            srxd_pkg::ADDR_BEGIN_B: next_s.rdata = srxd_pkg::ADDR_REG_HIGH |
              field_word(s.begin_addr[srxd_pkg::BUF_B]);
            srxd_pkg::ADDR_END_B: next_s.rdata = srxd_pkg::ADDR_REG_HIGH |
              field_word(s.end_addr[srxd_pkg::BUF_B]);
            srxd_pkg::ADDR_WR_OFS_A: next_s.rdata =
              field_word(buf_offset[srxd_pkg::BUF_A]);
            srxd_pkg::ADDR_WR_OFS_B: next_s.rdata =
              field_word(buf_offset[srxd_pkg::BUF_B]);
            srxd_pkg::ADDR_ERR_A: next_s.rdata =
              field_word(buf_err_offset[srxd_pkg::BUF_A]);
            srxd_pkg::ADDR_ERR_B: next_s.rdata =
              field_word(buf_err_offset[srxd_pkg::BUF_B]);
            srxd_pkg::ADDR_SAVED: next_s.rdata =
              field_word(s.saved_count);
            srxd_pkg::ADDR_CTRL: next_s.rdata[srxd_pkg::CTRL_SPI_SLV] =
              s.spi_slave;
            srxd_pkg::ADDR_STAT: begin
              next_s.rdata[srxd_pkg::STAT_LOADED_A] =
                buf_loaded[srxd_pkg::BUF_A];
              next_s.rdata[srxd_pkg::STAT_LOADED_B] =
                buf_loaded[srxd_pkg::BUF_B];
              next_s.rdata[srxd_pkg::STAT_ACTIVE_B] = s.active_b;
              next_s.rdata[srxd_pkg::STAT_SAVED]    = s.saved_valid;
            end
            srxd_pkg::ADDR_INT_STAT: next_s.rdata =
              {{(32-srxd_pkg::EV_W){1'b0}}, s.int_status};
            srxd_pkg::ADDR_INT_MASK: next_s.rdata =
              {{(32-srxd_pkg::EV_W){1'b0}}, s.int_mask};
            default: next_s.rdata = '0;
          endcase
        end
      end
      srxd_pkg::BUS_ACK: begin
        next_s.bus = srxd_pkg::BUS_IDLE;
      end
      default: next_s.bus = srxd_pkg::BUS_IDLE;
    endcase

    // Register writes at the answer edge; last-byte addresses set the end.
    if (wr_go) begin
      case (avs_address_i)
        srxd_pkg::ADDR_BEGIN_A: next_s.begin_addr[srxd_pkg::BUF_A] =
          OFS_W'(be_merge(field_word(s.begin_addr[srxd_pkg::BUF_A]),
                          avs_writedata_i, avs_byteenable_i));
        srxd_pkg::ADDR_END_A: next_s.end_addr[srxd_pkg::BUF_A] =
          OFS_W'(be_merge(field_word(s.end_addr[srxd_pkg::BUF_A]),
                          avs_writedata_i, avs_byteenable_i));
        srxd_pkg::ADDR_BEGIN_B: next_s.begin_addr[srxd_pkg::BUF_B] =
          OFS_W'(be_merge(field_word(s.begin_addr[srxd_pkg::BUF_B]),
                          avs_writedata_i, avs_byteenable_i));
        srxd_pkg::ADDR_END_B: next_s.end_addr[srxd_pkg::BUF_B] =
          OFS_W'(be_merge(field_word(s.end_addr[srxd_pkg::BUF_B]),
                          avs_writedata_i, avs_byteenable_i));
        srxd_pkg::ADDR_CTRL: begin
          if (avs_byteenable_i[0]) begin
            next_s.spi_slave = avs_writedata_i[srxd_pkg::CTRL_SPI_SLV];
          end
        end
        srxd_pkg::ADDR_INT_MASK: next_s.int_mask = avs_byteenable_i[0] ?
          avs_writedata_i[srxd_pkg::EV_W-1:0] : s.int_mask;
        default: ;
      endcase
    end

    // Sticky status: a new event wins over a clear in the same cycle.
    next_s.int_status = (s.int_status & ~int_clear) | events;

    // Active buffer follows stores; a full buffer hands over to the other.
    if (dma_rst) begin
      next_s.active_b = 1'b0;
    end else if (store_go) begin
      next_s.active_b = buf_at_end[sel_b] ? !sel_b : sel_b;
    end

    // Saved count: only the first deassertion after a DMA reset counts.
    next_s.ss_n_prev = slave_select_n_i;
    if (dma_rst) begin
      next_s.saved_valid = 1'b0;
      next_s.saved_count = '0;
    end else if (ss_deassert && !s.saved_valid) begin
      next_s.saved_valid = 1'b1;
      next_s.saved_count = cur_count;
    end

    // One byte write towards RAM per store.
    next_s.mem.wr = store_go;
    if (store_go) begin
      next_s.mem.addr = OFS_W'(s.begin_addr[sel_b] + buf_offset[sel_b]);
      next_s.mem.data = rx_byte_i.data;
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      s <= srxd_pkg::TOP_RESET;
    end else if (clk_en_i) begin
      s <= next_s;
    end
  end

endmodule // srxd_top

// ---- test/serial_rx_dma_count_error_track_tb_top.sv ----
// Self-checking bench of the receive DMA tracker against a behavioural model.
`timescale 1ns/1ps
module serial_rx_dma_count_error_track_tb_top;
  // Design ports.
  logic                    ref_clk_i;
  logic                    sys_rst_i;
  logic                    clk_en_i;
  logic [31:0]             avs_address_i;
  logic                    avs_read_i;
  logic                    avs_write_i;
  logic [31:0]             avs_writedata_i;
  logic [3:0]              avs_byteenable_i;
  logic [31:0]             avs_readdata_o;
  logic                    avs_waitrequest_o;
  srxd_pkg::srxd_rx_byte_t rx_byte_i;
  logic                    rx_ready_o;
  logic                    slave_select_n_i;
  srxd_pkg::srxd_mem_wr_t  mem_wr_o;
  logic                    irq_o;
  // Counters and the model of both buffers.
  int                      err_count;
  int                      check_count;
  int                      beg[2] = '{'h10, 'h100};
  int                      fin[2] = '{'h13, 'h3ff};
  int                      ofs[2];
  int                      ld[2];
  int                      erv[2];
  int                      ero[2];
  int                      act;
  int                      ev;

  // Device under test and the receive FIFO model.
  srxd_top #(.OFS_W(14)) dut_u (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .rx_byte_i(rx_byte_i),
    .rx_ready_o(rx_ready_o), .slave_select_n_i(slave_select_n_i),
    .mem_wr_o(mem_wr_o), .irq_o(irq_o));
  srxd_fifo_model fifo_u (
    .ref_clk_i(ref_clk_i), .rx_ready_i(rx_ready_o), .rx_byte_o(rx_byte_i));

  // Clock at 100 ns.
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  // Compares one value and reports a mismatch.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic results();
    if (err_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // One Avalon transfer, held until waitrequest is seen low.
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    avs_writedata_i <= ~d;
    if (n >= 50) begin
      err_count++;
      results();
    end
    @(posedge ref_clk_i);
  endtask

  // Register read with comparison, and register write.
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  // Offers one byte, checks its store and advances the model.
  task automatic put(input logic [7:0] d, input logic [2:0] e);
    int b;
    b = ld[act] ? act : 1 - act;
    fifo_u.send(d, e, $urandom % 3);
    @(negedge ref_clk_i);
    chk(mem_wr_o, {1'b1, 14'(beg[b] + ofs[b]), d});
    if (e != 0 && erv[b] == 0) begin
      erv[b] = 1;
      ero[b] = (e == 3'b001) ? (ofs[b] - 4) & 'h3fff : ofs[b];
      ev |= 4 << b;
    end
    if (beg[b] + ofs[b] == fin[b]) begin
      ld[b] = 0;
      act = 1 - b;
      ev |= 1 << b;
    end
    ofs[b]++;
    @(posedge ref_clk_i);
  endtask

  // Slave select pulse, and an interrupt level check.
  task automatic ssel();
    slave_select_n_i <= 1'b0;
    @(posedge ref_clk_i);
    slave_select_n_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
  endtask
  task automatic qirq(input logic e);
    @(negedge ref_clk_i);
    chk(irq_o, e);
    @(posedge ref_clk_i);
  endtask

  // Watchdog against a hung handshake.
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    err_count++;
    results();
  end

  // Main sequence.
  initial begin
    void'($urandom(49));
    {sys_rst_i, clk_en_i, slave_select_n_i} = 3'b111;
    {avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
    avs_byteenable_i = 4'hf;
    repeat (3) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    rd(srxd_pkg::ADDR_WR_OFS_B, 0);
    rd(srxd_pkg::ADDR_ERR_A, 0);
    rd(srxd_pkg::ADDR_ERR_B, 0);
    rd(srxd_pkg::ADDR_SAVED, 0);
    rd(32'h4000c8f0, 0);
    for (int i = 0; i < 4; i++)
      wr(32'h4000c800 + 4 * i, i[0] ? fin[i/2] : beg[i/2]);
    rd(srxd_pkg::ADDR_END_A, 32'h20000013);
    wr(srxd_pkg::ADDR_CTRL, 1 << srxd_pkg::CTRL_LOAD_A);
    ld = '{1, 1};
    ofs[1] = $urandom % 64;
    wr(srxd_pkg::ADDR_WR_OFS_B, ofs[1]);
    rd(srxd_pkg::ADDR_WR_OFS_B, ofs[1]);
    rd(srxd_pkg::ADDR_STAT, 3);
    wr(srxd_pkg::ADDR_INT_MASK, 1 << srxd_pkg::EV_ERR_B);
    for (int i = 0; i < 4; i++) put(8'($urandom), 3'(i << 1));
    rd(srxd_pkg::ADDR_ERR_A, ero[0]);
    rd(srxd_pkg::ADDR_STAT, 6);
    qirq(1'b0);
    for (int i = 0; i < 3; i++) put(8'($urandom), 3'(i));
    rd(srxd_pkg::ADDR_ERR_B, ero[1]);
    rd(srxd_pkg::ADDR_WR_OFS_B, ofs[1]);
    qirq(1'b1);
    rd(srxd_pkg::ADDR_INT_STAT, ev);
    wr(srxd_pkg::ADDR_INT_STAT, 1 << srxd_pkg::EV_ERR_B);
    ev &= ~8;
    qirq(1'b0);
    rd(srxd_pkg::ADDR_INT_STAT, ev);
    wr(srxd_pkg::ADDR_CTRL, 1 << srxd_pkg::CTRL_SPI_SLV);
    ssel();
    rd(srxd_pkg::ADDR_SAVED, ofs[1]);
    put(8'($urandom), 3'b000);
    ssel();
    rd(srxd_pkg::ADDR_SAVED, ofs[1] - 1);
    wr(srxd_pkg::ADDR_CTRL, 1 << srxd_pkg::CTRL_LOAD_B);
    ofs[1] = 0;
    rd(srxd_pkg::ADDR_WR_OFS_B, 0);
    rd(srxd_pkg::ADDR_ERR_B, 0);
    put(8'($urandom), 3'b000);
    wr(srxd_pkg::ADDR_CTRL, 1 << srxd_pkg::CTRL_DMA_RST);
    rd(srxd_pkg::ADDR_WR_OFS_B, 0);
    rd(srxd_pkg::ADDR_SAVED, 0);
    rd(srxd_pkg::ADDR_ERR_A, 0);
    rd(srxd_pkg::ADDR_STAT, 0);
    wr(srxd_pkg::ADDR_WR_OFS_A, 7);
    rd(srxd_pkg::ADDR_STAT, 1);
    rd(srxd_pkg::ADDR_WR_OFS_A, 7);
    results();
  end
endmodule // serial_rx_dma_count_error_track_tb_top

// ---- test/srxd_assertions.sv ----
// Port-level assertions of the receive DMA tracker.
`timescale 1ns/1ps
module srxd_checker #(
  parameter int OFS_W = 14
) (
  // Clock, reset and enable.
  input wire logic                    ref_clk_i,
  input wire logic                    sys_rst_i,
  input wire logic                    clk_en_i,
  // Avalon-MM slave.
  input wire logic [31:0]             avs_address_i,
  input wire logic                    avs_read_i,
  input wire logic                    avs_write_i,
  input wire logic [31:0]             avs_writedata_i,
  input wire logic [3:0]              avs_byteenable_i,
  input wire logic [31:0]             avs_readdata_o,
  input wire logic                    avs_waitrequest_o,
  // Receive stream, select, memory writes and interrupt.
  input wire srxd_pkg::srxd_rx_byte_t rx_byte_i,
  input wire logic                    rx_ready_o,
  input wire logic                    slave_select_n_i,
  input wire srxd_pkg::srxd_mem_wr_t  mem_wr_o,
  input wire logic                    irq_o
);
  logic req;
  logic take;
  logic wr_ok;
  logic rd_ok;
  // Decoded handshakes shared by the properties.
  assign req = avs_read_i | avs_write_i;
  assign take = rx_byte_i.valid & rx_ready_o & clk_en_i;
  assign wr_ok = avs_write_i & !avs_waitrequest_o & clk_en_i;
  assign rd_ok = avs_read_i & !avs_waitrequest_o;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  bus_one_wait_a: assert property (req && avs_waitrequest_o && clk_en_i
    |=> !avs_waitrequest_o || !clk_en_i)
    else $error("Bus answer missed its cycle.");
  bus_idle_quiet_a: assert property (!req |-> !avs_waitrequest_o)
    else $error("Wait asserted with no request.");
  rdata_hold_a: assert property (rd_ok |=> $stable(avs_readdata_o))
    else $error("Read data changed right after the answer.");
  store_pulse_a: assert property (take |=> mem_wr_o.wr)
    else $error("Accepted byte gave no memory write.");
  store_only_a: assert property (!take |=> !mem_wr_o.wr)
    else $error("Memory write without an accepted byte.");
  dma_reset_a: assert property (wr_ok && avs_writedata_i[2:0] == 3'h1
    && avs_address_i == srxd_pkg::ADDR_CTRL |=> !rx_ready_o)
    else $error("Buffers still loaded after DMA reset.");
  load_b_a: assert property (wr_ok
    && avs_address_i == srxd_pkg::ADDR_WR_OFS_B |=> rx_ready_o || !clk_en_i)
    else $error("Offset write did not load buffer B.");
  load_a_a: assert property (wr_ok && (avs_address_i ==
    srxd_pkg::ADDR_WR_OFS_A || avs_address_i == srxd_pkg::ADDR_CTRL
    && avs_writedata_i[2:0] == 3'h2) |=> rx_ready_o || !clk_en_i)
    else $error("Buffer A did not load.");
  err_field_a: assert property (rd_ok
    && avs_address_i == srxd_pkg::ADDR_ERR_A |-> avs_readdata_o[31:14] == '0)
    else $error("Error offset exceeds its field.");
  saved_field_a: assert property (rd_ok
    && avs_address_i == srxd_pkg::ADDR_SAVED |-> avs_readdata_o[31:14] == '0)
    else $error("Saved count exceeds its field.");

  // Main scenarios reached.
  cover property (take && rx_byte_i.overflow_err);
  cover property (irq_o);
  cover property (rd_ok && avs_address_i == srxd_pkg::ADDR_SAVED);
endmodule // srxd_checker

bind srxd_top srxd_checker #(.OFS_W(OFS_W)) chk_u (
  .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .rx_byte_i(rx_byte_i),
  .rx_ready_o(rx_ready_o), .slave_select_n_i(slave_select_n_i),
  .mem_wr_o(mem_wr_o), .irq_o(irq_o));

// ---- test/srxd_fifo_model.sv ----
// Receive FIFO model that offers bytes to the tracker.
`timescale 1ns/1ps
module srxd_fifo_model (
  // Clock.
  input  wire logic               ref_clk_i,
  // Byte handshake.
  input  wire logic               rx_ready_i,
  output srxd_pkg::srxd_rx_byte_t rx_byte_o
);
  // Nothing is offered until the first byte.
  initial rx_byte_o = '0;

  // Stalls, holds the byte until taken, then scrambles the released fields.
  task automatic send(input logic [7:0] d, input logic [2:0] e, input int gap);
    repeat (gap) @(posedge ref_clk_i);
    rx_byte_o <= {1'b1, d, e};
    do @(posedge ref_clk_i); while (rx_ready_i !== 1'b1);
    rx_byte_o <= {1'b0, ~d, ~e};
  endtask
endmodule // srxd_fifo_model
